// ==== sasi_host_data_irq_port_tb.sv ====
`timescale 1ns/1ns
module sasi_host_data_irq_port_tb
    import sdp_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cpu_sel = 1'b0, cpu_wr = 1'b0, cpu_iack = 1'b0, hold_rx = 1'b0;
    logic [23:0] cpu_addr = 24'h000000;
    logic [1:0] cpu_size = 2'h0;
    logic [31:0] cpu_wdata = 32'h00000000;
    logic usr_bsy = 1'b0, usr_cd = 1'b0, usr_io = 1'b0, usr_msg = 1'b0;
    logic tx_valid = 1'b0, rx_ready = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [31:0] cpu_rdata, rd;
    logic cpu_done, cpu_berr, irq1, tx_ready, rx_valid;
    logic [7:0] rx_data;
    logic [31:0] seed = 32'h00004344;
    int errors = 0, n_compared = 0;
    logic [7:0] txq[$], rxq[$];
    logic [1:0] sizes[3] = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG};

    always #4 clock = ~clock;

    sdp_link_if i_sdp_link_if ();
    sdp_board i_sdp_board (.clock(clock), .rst(rst), .link(i_sdp_link_if), .cpu_sel(cpu_sel),
        .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_size(cpu_size), .cpu_wdata(cpu_wdata),
        .cpu_iack(cpu_iack), .cpu_rdata(cpu_rdata), .cpu_done(cpu_done), .cpu_berr(cpu_berr),
        .irq1(irq1));
    sdp_ctrl i_sdp_ctrl (.clock(clock), .rst(rst), .link(i_sdp_link_if), .usr_bsy(usr_bsy),
        .usr_cd(usr_cd), .usr_io(usr_io), .usr_msg(usr_msg), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data));
    sdp_link_assertions i_sdp_link_assertions (.clock(clock), .rst(rst),
        .req(i_sdp_link_if.req), .ack(i_sdp_link_if.ack), .bsy(i_sdp_link_if.bsy),
        .cd(i_sdp_link_if.cd), .io(i_sdp_link_if.io), .msg(i_sdp_link_if.msg),
        .lrst(i_sdp_link_if.rst), .h_oe(i_sdp_link_if.h_oe), .irq1(irq1), .cpu_iack(cpu_iack));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Byte i of a transfer, most significant of the size first
    function automatic logic [7:0] pick(input logic [31:0] wd, input logic [1:0] sz, input int i);
        return wd[8 * (int'(sz) - i) +: 8];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [23:0] a, input logic [1:0] sz,
        input logic [31:0] wd, input logic exp_berr);
        int n;
        // One idle edge keeps strobes of back-to-back calls apart
        @(posedge clock);
        #1 cpu_sel = 1'b1;
        cpu_wr = wr;
        cpu_addr = a;
        cpu_size = sz;
        cpu_wdata = wd;
        @(posedge clock);
        #1 cpu_sel = 1'b0;
        n = 0;
        while (cpu_done !== 1'b1 && cpu_berr !== 1'b1 && n < 2000)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 2000)
        begin
            errors++;
            conclude();
        end
        check("bus_error", cpu_berr, exp_berr);
        rd = cpu_rdata;
    endtask

    task automatic wr_data(input logic [1:0] sz, input logic [31:0] wd);
        for (int i = 0; i <= int'(sz); i++)
            rxq.push_back(pick(wd, sz, i));
        acc(1'b1, DATA_PORT_ADDR + 24'(rnd() % 4), sz, wd, 1'b0);
    endtask

    task automatic rd_data(input logic [1:0] sz);
        logic [31:0] e;
        logic [7:0] b;
        e = 32'h00000000;
        for (int i = 0; i <= int'(sz); i++)
        begin
            b = 8'(rnd());
            txq.push_back(b);
            e = {e[23:0], b};
        end
        acc(1'b0, DATA_PORT_ADDR + 24'(rnd() % 4), sz, 32'h00000000, 1'b0);
        check("read_data", rd & ((32'h00000001 << (8 * (int'(sz) + 1))) - 32'h00000001), e);
    endtask

    task automatic irq_is(input logic v, input int cyc);
        repeat (cyc) @(posedge clock);
        #1 check("irq1", irq1, v);
    endtask

    task automatic vector_fetch();
        cpu_iack = 1'b1;
        @(posedge clock);
        #1 cpu_iack = 1'b0;
    endtask

    task automatic drain();
        for (int n = 0; n < 500 && rxq.size() > 0; n++)
            @(posedge clock);
        #1 check("drained", rxq.size(), 0);
    endtask

    // Handshakes judged mid-cycle, where both sides are settled
    always @(negedge clock)
    begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            check("rx_data", {24'h000000, rx_data}, {24'h000000, rxq.pop_front()});
        if (tx_ready === 1'b1 && tx_valid === 1'b1)
            void'(txq.pop_front());
    end

    always @(posedge clock)
    begin
        #1 rx_ready = !hold_rx && rnd() > 32'h55555555;
        tx_valid = txq.size() > 0;
        tx_data = (txq.size() > 0) ? txq[0] : 8'(rnd());
    end

    initial
    begin
        repeat (20) @(posedge clock);
        #1 check("link_rst_held", i_sdp_link_if.rst, 1'b1);
        rst = 1'b0;
        repeat (2) @(posedge clock);
        #1 check("link_rst_free", i_sdp_link_if.rst, 1'b0);
        // One controller alone on the link owns its address
        acc(1'b0, IRQ_ARM_ADDR, SIZE_BYTE, 32'h00000000, 1'b1);
        acc(1'b1, 24'hFF8010, SIZE_BYTE, 32'h00000000, 1'b1);
        acc(1'b0, 24'hFF8007, SIZE_WORD, 32'h00000000, 1'b1);
        $display("test address map done");
        // Data read phase: busy, to host, no message
        {usr_bsy, usr_cd, usr_io, usr_msg} = 4'hA;
        for (int i = 0; i < 12; i++)
            rd_data((i < 3) ? sizes[i] : sizes[rnd() % 3]);
        txq.push_back(8'h5A);
        acc(1'b1, DATA_PORT_ADDR, SIZE_BYTE, 32'h00000000, 1'b1);
        acc(1'b0, DATA_PORT_ADDR, SIZE_BYTE, 32'h00000000, 1'b0);
        check("read_after_berr", {24'h000000, rd[7:0]}, 32'h0000005A);
        $display("test reads done");
        {usr_bsy, usr_cd, usr_io, usr_msg} = 4'hF;
        acc(1'b1, IRQ_ARM_ADDR, SIZE_BYTE, rnd(), 1'b0);
        irq_is(1'b0, 3);
        txq.push_back(8'h3C);
        irq_is(1'b1, 8);
        vector_fetch();
        irq_is(1'b0, 3);
        acc(1'b1, IRQ_ARM_ADDR, SIZE_BYTE, rnd(), 1'b0);
        irq_is(1'b1, 2);
        acc(1'b0, DATA_PORT_ADDR, SIZE_BYTE, 32'h00000000, 1'b0);
        irq_is(1'b0, 3);
        txq.push_back(8'hC3);
        irq_is(1'b1, 8);
        vector_fetch();
        acc(1'b0, DATA_PORT_ADDR, SIZE_BYTE, 32'h00000000, 1'b0);
        irq_is(1'b0, 3);
        {usr_bsy, usr_cd, usr_io, usr_msg} = 4'hC;
        acc(1'b1, IRQ_ARM_ADDR, SIZE_BYTE, rnd(), 1'b0);
        irq_is(1'b0, 8);
        usr_bsy = 1'b0;
        wr_data(SIZE_BYTE, rnd());
        $display("test interrupts done");
        {usr_bsy, usr_cd, usr_io, usr_msg} = 4'h8;
        for (int i = 0; i < 12; i++)
            wr_data((i < 3) ? sizes[i] : sizes[rnd() % 3], rnd());
        acc(1'b0, DATA_PORT_ADDR, SIZE_LONG, 32'h00000000, 1'b1);
        hold_rx = 1'b0;
        drain();
        // FIFO is empty here, so the late rx_ready update pops nothing
        hold_rx = 1'b1;
        for (int i = 0; i < 8; i++)
            wr_data(SIZE_BYTE, rnd());
        acc(1'b1, DATA_PORT_ADDR, SIZE_BYTE, 32'h000000FF, 1'b1);
        check("fifo_full", rx_valid, 1'b1);
        hold_rx = 1'b0;
        drain();
        $display("test writes done");
        conclude();
    end
endmodule

// ==== sdp_board.sv ====
// Function
// - Data port decoded at four bytes from FF8008
// - Byte, word, long accesses split into bytes
// - Processor sizes access to remaining byte count
// - Per-byte response time-out raises bus error
// - Wrong direction against IO raises bus error
// - Link reset driven from system reset
// - Software cannot assert link reset alone
// - Controller resets itself on link reset
// - Logic clocked at processor clock rate
// - Phase lines valid no later than REQ
// - Phase lines stable until ACK negates
// - Write data driven before ACK asserts
// - ACK negates after REQ, minimum gap
// - Level one interrupt on data, status requests
// - Command requests never interrupt
// - Pending request interrupts at once when armed
// - Vector fetch disarms until next arm write
// - Vanished request withdraws interrupt, stays armed
// - One controller alone on the link; no selection
// - Any byte write arms; read bus errors
// - Status request ignores MSG line
`timescale 1ns/1ns
module sdp_board
    import sdp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    sdp_link_if.board link,
    input wire logic cpu_sel,
    input wire logic cpu_wr,
    input wire logic [23:0] cpu_addr,
    input wire logic [1:0] cpu_size,
    input wire logic [31:0] cpu_wdata,
    input wire logic cpu_iack,
    output logic [31:0] cpu_rdata,
    output logic cpu_done,
    output logic cpu_berr,
    output logic irq1
);
    sdp_hstate_t st_q;
    sdp_hstate_t st_d;
    logic [31:0] sh_q;
    logic [31:0] sh_d;
    logic [1:0] left_q;
    logic [1:0] left_d;
    logic wr_q;
    logic wr_d;
    logic [11:0] tmo_q;
    logic [11:0] tmo_d;
    logic [4:0] dly_q;
    logic [4:0] dly_d;
    logic ack_q;
    logic ack_d;
    logic oe_q;
    logic oe_d;
    logic done_q;
    logic done_d;
    logic berr_q;
    logic berr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic arm_q;
    logic irq_q;
    logic lrst_q;

    wire hit_data = (cpu_addr[23:2] == DATA_PORT_ADDR[23:2]);
    wire hit_arm = (cpu_addr == IRQ_ARM_ADDR);
    wire arm_write = cpu_sel && (st_q == ST_IDLE) && hit_arm && cpu_wr;
    wire req_seen = link.req && link.bsy;
    wire cpu_wr_q_dir = wr_q;
    // Read wants io high, write wants io low
    wire dir_bad = (cpu_wr_q_dir && link.io) || (!cpu_wr_q_dir && !link.io);
    wire timed_out = (tmo_q >= TIMEOUT_CYC);
    wire [4:0] shift_amt = 5'({3'h3 - {1'b0, cpu_size}, 3'h0});
    wire [31:0] sh_load = cpu_wdata << shift_amt;

    wire want_write = link.req && !link.msg && link.bsy && !link.cd && !link.io;
    wire want_read = link.req && !link.msg && link.bsy && !link.cd && link.io;
    wire want_stat = link.req && link.bsy && link.cd && link.io;
    wire irq_cond = want_write || want_read || want_stat;

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        left_d = left_q;
        wr_d = wr_q;
        tmo_d = tmo_q;
        dly_d = dly_q;
        ack_d = ack_q;
        oe_d = oe_q;
        done_d = 1'b0;
        berr_d = 1'b0;
        rdata_d = rdata_q;
        case (st_q)
            ST_IDLE:
            begin
                if (cpu_sel && hit_data)
                begin
                    st_d = ST_WAIT_REQ;
                    wr_d = cpu_wr;
                    left_d = cpu_size;
                    sh_d = sh_load;
                    tmo_d = 12'h000;
                    rdata_d = 32'h0000_0000;
                end
                else if (cpu_sel && hit_arm && cpu_wr)
                    done_d = 1'b1;
                else if (cpu_sel)
                    berr_d = 1'b1;
            end
            ST_WAIT_REQ:
            begin
                tmo_d = tmo_q + 12'h001;
                if (req_seen && dir_bad)
                begin
                    berr_d = 1'b1;
                    st_d = ST_IDLE;
                end
                else if (req_seen)
                begin
                    oe_d = wr_q;
                    dly_d = wr_q ? ACK_DLY_WR : ACK_DLY_RD;
                    st_d = ST_ACK_DLY;
                end
                else if (timed_out)
                begin
                    berr_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_ACK_DLY:
            begin
                dly_d = dly_q - 5'h01;
                if (dly_q <= 5'h01)
                begin
                    ack_d = 1'b1;
                    tmo_d = 12'h000;
                    st_d = ST_ACK;
                    if (!wr_q)
                        rdata_d = {rdata_q[23:0], link.data};
                end
            end
            ST_ACK:
            begin
                tmo_d = tmo_q + 12'h001;
                if (!link.req)
                begin
                    dly_d = wr_q ? ACK_REL_WR : ACK_REL_RD;
                    st_d = ST_RELEASE;
                end
                else if (timed_out)
                begin
                    ack_d = 1'b0;
                    oe_d = 1'b0;
                    berr_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_RELEASE:
            begin
                dly_d = dly_q - 5'h01;
                if (dly_q <= 5'h01)
                begin
                    ack_d = 1'b0;
                    oe_d = 1'b0;
                    if (left_q == 2'h0)
                    begin
                        done_d = 1'b1;
                        st_d = ST_IDLE;
                    end
                    else
                    begin
                        // Next byte gets a fresh time-out
                        left_d = left_q - 2'h1;
                        sh_d = {sh_q[23:0], 8'h00};
                        tmo_d = 12'h000;
                        st_d = ST_WAIT_REQ;
                    end
                end
            end
            default:
            begin
                st_d = ST_IDLE;
                ack_d = 1'b0;
                oe_d = 1'b0;
            end
        endcase
    end

    // One clock for all state, the processor clock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            sh_q <= 32'h0000_0000;
            left_q <= 2'h0;
            wr_q <= 1'b0;
            tmo_q <= 12'h000;
            dly_q <= 5'h00;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            berr_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            left_q <= left_d;
            wr_q <= wr_d;
            tmo_q <= tmo_d;
            dly_q <= dly_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            done_q <= done_d;
            berr_q <= berr_d;
            rdata_q <= rdata_d;
        end
    end

    // Arm write wins over a same-cycle vector fetch
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            arm_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            if (arm_write)
                arm_q <= 1'b1;
            else if (cpu_iack && irq_q)
                arm_q <= 1'b0;
            irq_q <= arm_q && irq_cond && !(cpu_iack && irq_q);
        end
    end

    // Link reset mirrors system reset only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            lrst_q <= 1'b1;
        else
            lrst_q <= 1'b0;
    end

    assign link.ack = ack_q;
    assign link.h_oe = oe_q;
    assign link.h_dout = sh_q[31:24];
    assign link.rst = lrst_q;
    assign cpu_rdata = rdata_q;
    assign cpu_done = done_q;
    assign cpu_berr = berr_q;
    assign irq1 = irq_q;
endmodule

// ==== sdp_ctrl.sv ====
`timescale 1ns/1ns
module sdp_ctrl
    import sdp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    sdp_link_if.ctrl link,
    input wire logic usr_bsy,
    input wire logic usr_cd,
    input wire logic usr_io,
    input wire logic usr_msg,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data
);
    sdp_cstate_t st_q;
    sdp_cstate_t st_d;
    logic req_q;
    logic bsy_q;
    logic cd_q;
    logic io_q;
    logic msg_q;
    logic oe_q;
    logic [7:0] dout_q;
    logic push_q;
    logic [7:0] rxb_q;
    logic txr_q;
    logic fifo_ready;

    wire start = (st_q == CS_IDLE) && usr_bsy && (usr_io ? tx_valid : fifo_ready);
    wire got_ack = (st_q == CS_REQ) && link.ack;
    wire done = (st_q == CS_ACK_LOW) && !link.ack;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            CS_IDLE: if (start) st_d = CS_REQ;
            CS_REQ: if (link.ack) st_d = CS_ACK_LOW;
            CS_ACK_LOW: if (!link.ack) st_d = CS_IDLE;
            default: st_d = CS_IDLE;
        endcase
    end

    // Link reset abandons any byte in flight
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= CS_IDLE;
            req_q <= 1'b0;
            bsy_q <= 1'b0;
            cd_q <= 1'b0;
            io_q <= 1'b0;
            msg_q <= 1'b0;
            oe_q <= 1'b0;
            dout_q <= 8'h00;
            push_q <= 1'b0;
            rxb_q <= 8'h00;
            txr_q <= 1'b0;
        end
        else if (link.rst)
        begin
            st_q <= CS_IDLE;
            req_q <= 1'b0;
            bsy_q <= 1'b0;
            oe_q <= 1'b0;
            push_q <= 1'b0;
            txr_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            push_q <= got_ack && !io_q;
            txr_q <= got_ack && io_q;
            if (st_q == CS_IDLE)
            begin
                // Phase lines move only between handshakes
                bsy_q <= usr_bsy;
                cd_q <= usr_cd;
                io_q <= usr_io;
                msg_q <= usr_msg;
            end
            if (start)
            begin
                req_q <= 1'b1;
                oe_q <= usr_io;
                dout_q <= tx_data;
            end
            if (got_ack)
            begin
                req_q <= 1'b0;
                rxb_q <= link.data;
            end
            if (done)
                oe_q <= 1'b0;
        end
    end

    assign link.req = req_q;
    assign link.bsy = bsy_q;
    assign link.cd = cd_q;
    assign link.io = io_q;
    assign link.msg = msg_q;
    assign link.c_dout = dout_q;
    assign link.c_oe = oe_q;
    assign tx_ready = txr_q;

    sdp_fifo #(
        .W(FIFO_WIDTH),
        .D(FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(clock),
        .rst(rst),
        .clr(link.rst),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(rxb_q),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );
endmodule

// ==== sdp_fifo.sv ====
`timescale 1ns/1ns
module sdp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];

    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else if (clr)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== sdp_link_assertions.sv ====
`timescale 1ns/1ns
module sdp_link_assertions
    import sdp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req,
    input wire logic ack,
    input wire logic bsy,
    input wire logic cd,
    input wire logic io,
    input wire logic msg,
    input wire logic lrst,
    input wire logic h_oe,
    input wire logic irq1,
    input wire logic cpu_iack
);
    logic [7:0] gap_q;
    // Data request without message, or status/message request; never command
    wire logic irq_cond = req && bsy && ((!cd && !msg) || (cd && io));

    // Cycles with ack still high after req dropped
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            gap_q <= 8'h00;
        else
            gap_q <= (ack && !req) ? gap_q + 8'h01 : 8'h00;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ack_after_req_a: assert property ($rose(ack) |-> req)
        else $error("ack rose without req");
    ack_drop_late_a: assert property ($fell(ack) |-> !req)
        else $error("ack fell while req high");
    wr_release_gap_a: assert property ($fell(ack) && !io |-> gap_q >= 8'(REL_WR_CYC))
        else $error("write ack released too soon");
    wr_data_lead_a: assert property ($rose(ack) && !io |-> h_oe && $past(h_oe))
        else $error("write data not driven before ack");
    phase_hold_a: assert property (ack && $past(ack) |-> $stable({cd, io, msg}))
        else $error("phase lines moved during ack");
    req_phase_a: assert property (req && $past(req) |-> $stable({bsy, cd, io, msg}))
        else $error("phase lines moved during req");
    lrst_only_a: assert property (lrst |-> $past(rst))
        else $error("link reset without system reset");
    irq_cause_a: assert property (irq1 |-> $past(irq_cond))
        else $error("interrupt without data or status request");
    irq_clear_a: assert property (irq1 && cpu_iack |=> !irq1)
        else $error("interrupt held after vector fetch");
    irq_drop_a: assert property (irq1 && !irq_cond |=> !irq1)
        else $error("interrupt held after request vanished");
    irq_hold_a: assert property (irq1 && irq_cond && !cpu_iack |=> irq1)
        else $error("interrupt lost while request stands");

    wr_byte_c: cover property ($rose(ack) && !io);
    msg_irq_c: cover property (irq1 && cd && io && msg);
    rd_byte_c: cover property ($rose(ack) && io);
    irq_served_c: cover property (irq1 && cpu_iack);
endmodule

// ==== sdp_link_if.sv ====
`timescale 1ns/1ns
interface sdp_link_if;
    logic req;
    logic ack;
    logic bsy;
    logic cd;
    logic io;
    logic msg;
    logic rst;
    logic [7:0] h_dout;
    logic h_oe;
    logic [7:0] c_dout;
    logic c_oe;
    logic [7:0] data;

    // Wired bus; idle lines float to all ones
    assign data = h_oe ? h_dout : (c_oe ? c_dout : 8'hFF);

    modport board (
        input req,
        input bsy,
        input cd,
        input io,
        input msg,
        input data,
        output ack,
        output rst,
        output h_dout,
        output h_oe
    );

    modport ctrl (
        output req,
        output bsy,
        output cd,
        output io,
        output msg,
        output c_dout,
        output c_oe,
        input data,
        input ack,
        input rst
    );
endinterface

// ==== sdp_pkg.sv ====
package sdp_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam logic [23:0] DATA_PORT_ADDR = 24'hFF8008;
    localparam logic [23:0] IRQ_ARM_ADDR = 24'hFF800C;
    localparam int WRITE_DATA_LEAD_TIME_NS = 10;
    localparam int REQ_TO_ACK_WR_NS = 40;
    localparam int REQ_TO_ACK_RD_NS = 110;
    localparam int ACK_RELEASE_WR_NS = 130;
    localparam int RESPONSE_TIMEOUT_LIMIT_NS = 10000;
    localparam int LEAD_CYC = (WRITE_DATA_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RTA_WR_CYC = (REQ_TO_ACK_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RTA_RD_CYC = (REQ_TO_ACK_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REL_WR_CYC = (ACK_RELEASE_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] ACK_DLY_WR = 5'((LEAD_CYC > RTA_WR_CYC) ? LEAD_CYC : RTA_WR_CYC);
    localparam logic [4:0] ACK_DLY_RD = 5'(RTA_RD_CYC);
    localparam logic [4:0] ACK_REL_WR = 5'(REL_WR_CYC);
    localparam logic [4:0] ACK_REL_RD = 5'h01;
    localparam logic [11:0] TIMEOUT_CYC = 12'(RESPONSE_TIMEOUT_LIMIT_NS / CLK_PERIOD_NS);
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 8;

    // Access size as byte count minus one
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_REQ = 3'b001,
        ST_ACK_DLY = 3'b010,
        ST_ACK = 3'b011,
        ST_RELEASE = 3'b100
    } sdp_hstate_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b00,
        CS_REQ = 2'b01,
        CS_ACK_LOW = 2'b10
    } sdp_cstate_t;
endpackage
